// *** inc/wwdt_pkg.sv ***
// Purpose: Shared constants and types for the windowed watchdog
// Assumes: 25 MHz system clock, 32 kHz nominal low-power oscillator
// Notes: Byte offsets are for a 32-bit classic Wishbone slave
package wwdt_pkg;
  // System clock and oscillator rates
  localparam int CLK_HZ = 25_000_000;
  localparam int LOW_POWER_RC_OSC_HZ = 32_000;
  // Clock cycles per oscillator tick (period, rounded down)
  localparam int LOW_POWER_RC_OSC_DIV = CLK_HZ / LOW_POWER_RC_OSC_HZ;
  // Base period of 1 ms expressed in oscillator ticks
  localparam int BASE_MS = 1;
  localparam int TICKS_PER_MS = (LOW_POWER_RC_OSC_HZ * BASE_MS) / 1000;
  // Power-up delay applied on a wake from Sleep
  localparam int POWER_UP_DELAY_TIMER_MS = 64;
  localparam int POWER_UP_DELAY_TIMER_TICKS = POWER_UP_DELAY_TIMER_MS * TICKS_PER_MS;
  // Counter and postscaler widths
  localparam int CNT_W = 26;
  localparam int PS_W = 5;
  localparam logic [4:0] PS_MAX = 5'h14;
  // Register map (byte addresses)
  localparam logic [7:0] CTL_OFS = 8'h00;
  localparam logic [7:0] RCF_OFS = 8'h10;
  // Alias operations selected by address bits 3:2
  localparam logic [1:0] OP_WR = 2'h0;
  localparam logic [1:0] OP_CLR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_INV = 2'h3;
  // Control register fields
  localparam int CTL_ON_BIT = 15;
  localparam int CTL_PS_LSB = 2;
  localparam int CTL_WIN_BIT = 1;
  localparam int CTL_SVC_BIT = 0;
  // Reset-cause fields
  localparam int RCF_TO_BIT = 4;
  localparam int RCF_SLP_BIT = 3;
  localparam int RCF_IDL_BIT = 2;
  // Reset values
  localparam logic RST_SW_ON = 1'b0;
  localparam logic RST_SW_WIN = 1'b0;
  // Window size encodings
  localparam logic [1:0] WIN_25 = 2'h3;
  localparam logic [1:0] WIN_37 = 2'h2;
  localparam logic [1:0] WIN_50 = 2'h1;
  localparam logic [1:0] WIN_75 = 2'h0;

  // Pins from the configuration fuses and the power manager
  typedef struct packed {
    logic nv_watchdog_enable;
    logic nv_window_enable;
    logic [1:0] nv_window_size;
    logic [4:0] postscaler_config;
    logic sleep;
    logic idle;
    logic irq_wake;
    logic power_up;
    logic osc_ready;
    logic power_up_delay_timer_enable;
  } wwdt_pins_t;

  // Wake sequencer states, one-hot
  typedef enum logic [2:0] {
    WK_RUN = 3'h1,
    WK_OSC = 3'h2,
    WK_POWER_UP_DELAY_TIMER = 3'h4
  } wwdt_wake_t;
endpackage : wwdt_pkg

// *** rtl/wwdt_top.sv ***
// Purpose: Windowed watchdog with Wishbone registers and wake sequencing
// Assumes: Oscillator modelled as a tick divider of the system clock
// Notes: Time-out flag survives device reset, cleared by power-up
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int DIV = LOW_POWER_RC_OSC_DIV,
  parameter int POWER_UP_DELAY_TIMER_CNT = POWER_UP_DELAY_TIMER_TICKS
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire wwdt_pins_t PINS_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic DEV_RESET_OUT,
  output logic NMI_WAKE_OUT,
  output logic EXEC_RESUME_OUT,
  output logic LOW_POWER_RC_OSC_ON_OUT
);

  // Clamp of the postscaler code, oversized codes act as the largest
  function automatic logic [4:0] ps_clamp(input logic [4:0] ps);
    ps_clamp = (ps > PS_MAX) ? PS_MAX : ps;
  endfunction : ps_clamp

  // Alias operation with byte lanes, unselected lanes keep old value
  function automatic logic [31:0] alias_op(input logic [1:0] op,
      input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] sel);
    logic [31:0] nv;
    logic [31:0] m;
    nv = '0;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    unique case (op)
      OP_WR: nv = wd;
      OP_CLR: nv = old & ~wd;
      OP_SET: nv = old | wd;
      OP_INV: nv = old ^ wd;
    endcase
    alias_op = (nv & m) | (old & ~m);
  endfunction : alias_op

  // Two-stage synchroniser for all outside pins
  wwdt_pins_t pin_meta; // First stage, read only by second
  wwdt_pins_t pin; // Safe synchronised copy
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pin_meta <= '0;
      pin <= '0;
    end else begin
      pin_meta <= PINS_IN;
      pin <= pin_meta;
    end
  end

  // Previous pin levels for edge detection
  logic sleep_d; // Last Sleep level
  logic idle_d; // Last Idle level
  logic wake_d; // Last interrupt-wake level
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sleep_d <= 1'b0;
      idle_d <= 1'b0;
      wake_d <= 1'b0;
    end else begin
      sleep_d <= pin.sleep;
      idle_d <= pin.idle;
      wake_d <= pin.irq_wake;
    end
  end

  // Event decode
  wire sleep_rise = pin.sleep & ~sleep_d;
  wire idle_rise = pin.idle & ~idle_d;
  wire pwr_save = pin.sleep | pin.idle;
  wire irq_exit = pin.irq_wake & ~wake_d & pwr_save;

  // Software state
  logic sw_on; // Software enable
  logic sw_win; // Software window enable
  logic [4:0] ps_shadow; // Postscaler shadow copy
  logic [1:0] ld_cnt; // Counts until synchroniser is valid

  // Running and mode decode; erased fuses read as ones and enable
  wire enabled = pin.nv_watchdog_enable | sw_on;
  wire win_mode = pin.nv_window_enable | sw_win;

  // Period and window threshold in oscillator ticks
  wire [4:0] ps_eff = ps_clamp(ps_shadow);
  wire [CNT_W-1:0] per = CNT_W'(TICKS_PER_MS) << ps_eff;
  wire [CNT_W-1:0] frac_25 = per >> 2;
  wire [CNT_W-1:0] frac_37 = (per >> 2) + (per >> 3);
  wire [CNT_W-1:0] frac_50 = per >> 1;
  wire [CNT_W-1:0] frac_75 = per - (per >> 2);
  wire [CNT_W-1:0] frac =
    (pin.nv_window_size == WIN_25) ? frac_25 :
    (pin.nv_window_size == WIN_37) ? frac_37 :
    (pin.nv_window_size == WIN_50) ? frac_50 : frac_75;
  wire [CNT_W-1:0] thr = per - frac;

  // Bus decode
  wire bus_req = WB_CYC_IN & WB_STB_IN;
  wire mapped = (WB_ADR_IN[7:5] == 3'h0) & (WB_ADR_IN[1:0] == 2'h0);
  wire hit_ctl = mapped & (WB_ADR_IN[4] == CTL_OFS[4]);
  wire hit_rcf = mapped & (WB_ADR_IN[4] == RCF_OFS[4]);
  wire [1:0] op = WB_ADR_IN[3:2];
  wire wr_now = bus_req & WB_ACK_OUT & WB_WE_IN;

  // Read views; the service bit always reads zero
  logic to_flag; // Time-out flag
  logic slp_flag; // Sleep event flag
  logic idl_flag; // Idle event flag
  wire [31:0] ctl_view = {16'h0000, enabled, 8'h00, ps_shadow,
    win_mode, 1'b0};
  wire [31:0] rcf_view = {27'h0, to_flag, slp_flag, idl_flag, 2'h0};
  wire [31:0] ctl_new = alias_op(op, ctl_view, WB_DAT_IN, WB_SEL_IN);
  wire [31:0] rcf_new = alias_op(op, rcf_view, WB_DAT_IN, WB_SEL_IN);
  wire ctl_wr = wr_now & hit_ctl;
  wire rcf_wr = wr_now & hit_rcf;

  // Service request and its window check
  logic [CNT_W-1:0] cnt; // Watchdog counter in ticks
  wire svc = ctl_wr & ctl_new[CTL_SVC_BIT];
  wire early = svc & enabled & win_mode & (cnt <= thr);

  // Oscillator tick divider, runs only while enabled
  logic [15:0] div_cnt; // Cycles within one oscillator tick
  wire tick = enabled & (div_cnt == 16'(DIV - 1));
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      div_cnt <= '0;
    end else if (!enabled || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // Time-out when the count reaches the period
  wire timeout = tick & (cnt >= per - CNT_W'(1));
  wire to_save = timeout & pwr_save;

  // Watchdog counter; not cleared on entering a power-saving mode
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cnt <= '0;
    end else if (svc || irq_exit || timeout || !enabled) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  // Software enable and window bits, cleared on device reset
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sw_on <= RST_SW_ON;
      sw_win <= RST_SW_WIN;
    end else if (ctl_wr) begin
      sw_on <= ctl_new[CTL_ON_BIT];
      sw_win <= ctl_new[CTL_WIN_BIT];
    end
  end

  // Shadow load once the synchroniser holds the fuse value
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ld_cnt <= 2'h0;
      ps_shadow <= 5'h00;
    end else if (ld_cnt != 2'h3) begin
      ld_cnt <= ld_cnt + 2'h1;
      ps_shadow <= pin.postscaler_config;
    end
  end

  // Sleep and Idle flags; hardware set wins over software clear
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      slp_flag <= 1'b0;
      idl_flag <= 1'b0;
    end else begin
      slp_flag <= (rcf_wr ? rcf_new[RCF_SLP_BIT] : slp_flag) |
        sleep_rise | (to_save & pin.sleep);
      idl_flag <= (rcf_wr ? rcf_new[RCF_IDL_BIT] : idl_flag) |
        idle_rise | (to_save & pin.idle);
    end
  end

  // Time-out flag must outlive the reset it causes, so only power-up
  // or a software write clears it; no asynchronous reset on purpose
  always_ff @(posedge CLK_IN) begin
    if (pin.power_up) begin
      to_flag <= 1'b0;
    end else begin
      to_flag <= (rcf_wr ? rcf_new[RCF_TO_BIT] : to_flag) |
        timeout;
    end
  end

  // Reset and wake pulses
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      DEV_RESET_OUT <= 1'b0;
      NMI_WAKE_OUT <= 1'b0;
      LOW_POWER_RC_OSC_ON_OUT <= 1'b0;
    end else begin
      DEV_RESET_OUT <= (timeout & ~pwr_save) | early;
      NMI_WAKE_OUT <= to_save;
      LOW_POWER_RC_OSC_ON_OUT <= enabled;
    end
  end

  // Wake sequencer: Sleep waits for clocks, Idle resumes at once
  wwdt_wake_t wk; // Sequencer state
  wwdt_wake_t next_wk; // Its next value
  logic [15:0] dly; // Power-up delay in ticks
  logic [15:0] next_dly; // Its next value
  logic next_go; // Resume pulse request
  wire ptick = div_cnt == 16'(DIV - 1);
  always_comb begin
    next_wk = wk;
    next_dly = dly;
    next_go = 1'b0;
    unique case (wk)
      WK_RUN: begin
        if (to_save && pin.sleep) begin
          next_wk = WK_OSC;
        end else if (to_save) begin
          next_go = 1'b1;
        end
      end
      WK_OSC: begin
        if (pin.osc_ready && pin.power_up_delay_timer_enable) begin
          next_wk = WK_POWER_UP_DELAY_TIMER;
          next_dly = '0;
        end else if (pin.osc_ready) begin
          next_wk = WK_RUN;
          next_go = 1'b1;
        end
      end
      WK_POWER_UP_DELAY_TIMER: begin
        if (dly >= 16'(POWER_UP_DELAY_TIMER_CNT - 1) && ptick) begin
          next_wk = WK_RUN;
          next_go = 1'b1;
        end else if (ptick) begin
          next_dly = dly + 16'h0001;
        end
      end
      default: begin
        next_wk = WK_RUN;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wk <= WK_RUN;
      dly <= '0;
      EXEC_RESUME_OUT <= 1'b0;
    end else begin
      wk <= next_wk;
      dly <= next_dly;
      EXEC_RESUME_OUT <= next_go;
    end
  end

  // The sequencer only leaves its idle state after a time-out, while
  // the watchdog runs, so ptick needs no enable term of its own

  // Bus answer: ack one cycle after request, data registered;
  // unmapped and alias reads return zero
  wire [31:0] rd_mux = !mapped || op != OP_WR ? 32'h0 :
    hit_ctl ? ctl_view : rcf_view;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0;
    end else begin
      WB_ACK_OUT <= bus_req & ~WB_ACK_OUT;
      WB_DAT_OUT <= rd_mux;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_early;
    svc && enabled && win_mode && cnt <= thr;
  endsequence
  sequence s_awake_to;
    timeout && !pwr_save;
  endsequence

  ack_single_a: assert property (
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held for two cycles");
  awake_reset_a: assert property (
    s_awake_to |=> DEV_RESET_OUT && !NMI_WAKE_OUT)
    else $error("awake time-out gave no reset");
  save_nmi_a: assert property (
    to_save |=> NMI_WAKE_OUT && !DEV_RESET_OUT && to_flag)
    else $error("power-saving time-out wrong");
  early_svc_a: assert property (
    s_early |=> DEV_RESET_OUT)
    else $error("early service did not reset");
  svc_clear_a: assert property (
    svc |=> cnt == '0)
    else $error("service did not clear counter");
  cfg_on_a: assert property (
    pin.nv_watchdog_enable && ctl_wr |=> enabled)
    else $error("configured watchdog stopped");
  osc_on_a: assert property (
    enabled ##1 enabled |-> LOW_POWER_RC_OSC_ON_OUT)
    else $error("oscillator off while enabled");
  idle_wake_a: assert property (
    to_save && pin.idle && !pin.sleep && wk == WK_RUN
      |=> EXEC_RESUME_OUT)
    else $error("idle wake delayed");
  sleep_wake_a: assert property (
    to_save && pin.sleep && wk == WK_RUN
      |=> !EXEC_RESUME_OUT ##0 wk == WK_OSC)
    else $error("sleep wake skipped oscillator wait");
  count_stop_a: assert property (
    !enabled |=> cnt == '0)
    else $error("stopped counter not held");
  read_on_a: assert property (
    bus_req && !WB_ACK_OUT && hit_ctl && op == OP_WR && enabled
      |=> WB_DAT_OUT[CTL_ON_BIT])
    else $error("enable bit read zero while running");
  to_sticky_a: assert property (
    to_flag && !pin.power_up && !rcf_wr |=> to_flag)
    else $error("time-out flag lost");
  // A timely service inside the window must not reset the device
  win_open_a: assert property (
    svc && enabled && win_mode && cnt > thr && !timeout
      |=> !DEV_RESET_OUT)
    else $error("service inside window gave reset");
  irq_clear_a: assert property (
    irq_exit |=> cnt == '0)
    else $error("interrupt wake did not clear counter");
endmodule : wwdt_top

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the windowed watchdog
// Assumes: Short oscillator divider and power-up delay keep runs brief
// Notes: A monitor counts event pulses; scenarios judge the counts
module tb_top
  import wwdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV_T = 4; // Clock cycles per oscillator tick
  localparam int POWER_UP_DELAY_TIMER_T = 3; // Power-up delay in ticks
  localparam logic [7:0] SET_A = CTL_OFS | 8'h08; // Control set alias
  localparam logic [7:0] CLR_A = CTL_OFS | 8'h04; // Control clear alias
  logic clk, rst_b, cyc, stb, we, ack, dev_rst, nmi, resume, osc_on;
  logic [7:0] adr; // Byte address
  logic [3:0] sel; // Byte lanes
  logic [31:0] dat_w, dat_r, q; // Bus data
  wwdt_pins_t pins; // Fuse and power-manager levels
  int num_errors = 0, n_checks = 0, cyc_n = 0; // Tallies
  int n_rst = 0, n_nmi = 0, n_res = 0, t_rst, t_nmi, t_res; // Events
  wwdt_top #(.DIV(DIV_T), .POWER_UP_DELAY_TIMER_CNT(POWER_UP_DELAY_TIMER_T)) dut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .PINS_IN(pins),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r),
    .WB_ACK_OUT(ack), .DEV_RESET_OUT(dev_rst), .NMI_WAKE_OUT(nmi),
    .EXEC_RESUME_OUT(resume), .LOW_POWER_RC_OSC_ON_OUT(osc_on));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Pulse monitor; also cuts a hang short
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (dev_rst === 1'b1) begin
      n_rst <= n_rst + 1;
      t_rst <= cyc_n;
    end
    if (nmi === 1'b1) begin
      n_nmi <= n_nmi + 1;
      t_nmi <= cyc_n;
    end
    if (resume === 1'b1) begin
      n_res <= n_res + 1;
      t_res <= cyc_n;
    end
    if (cyc_n == 30000) begin
      num_errors++;
      final_report();
    end
  end
  // Single comparison point
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1);
    check("bus ack", i, 2);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // Wait, bounded, for an event counter to move past old
  task automatic wait_ev(ref int cnt, input int old, input int lim);
    int i;
    for (i = 0; i < lim && cnt == old; i++) @(posedge clk);
    check("event seen", cnt > old, 1);
  endtask : wait_ev
  // Device reset, then time for the shadow to load
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : do_reset
  // Reset values, read-only shadow, alias and unmapped reads
  task automatic s_regs();
    pins.postscaler_config <= 5'h15;
    do_reset();
    wb(0, CTL_OFS, 0);
    check("ctl reset", q, 32'h54);
    wb(1, 8'h20, 32'hffffffff);
    wb(1, CTL_OFS, 32'h7c);
    wb(0, CTL_OFS, 0);
    check("ctl ro", q, 32'h54);
    wb(0, SET_A, 0);
    check("alias read", q, 0);
    wb(0, 8'h20, 0);
    check("unmapped", q, 0);
    pins.postscaler_config <= 5'h00;
    do_reset();
  endtask : s_regs
  // Start and stop by set, clear and invert aliases
  task automatic s_enable();
    wb(1, SET_A, 32'h8000);
    wb(0, CTL_OFS, 0);
    check("on set", q, 32'h8000);
    check("osc on", osc_on, 1);
    wb(1, CLR_A, 32'h8000);
    wb(0, CTL_OFS, 0);
    check("on clr", q, 0);
    wb(1, CTL_OFS | 8'h0c, 32'h8000);
    wb(0, CTL_OFS, 0);
    check("on inv", q, 32'h8000);
    wb(1, CTL_OFS | 8'h0c, 32'h8000);
    repeat (2) @(posedge clk);
    check("osc off", osc_on, 0);
  endtask : s_enable
  // Time-out period for two codes, sticky flag across reset
  task automatic s_period();
    int c, t0, old, exp;
    for (c = 0; c < 2; c++) begin
      pins.postscaler_config <= 5'(c);
      do_reset();
      old = n_rst;
      wb(1, SET_A, 32'h8000);
      t0 = cyc_n;
      exp = (32 << c) * DIV_T;
      wait_ev(n_rst, old, 400);
      check("period", (t_rst - t0 > exp - 12) && (t_rst - t0 < exp + 12),
            1);
      wb(0, RCF_OFS, 0);
      check("to flag", q[RCF_TO_BIT], 1);
      do_reset();
      wb(0, RCF_OFS, 0);
      check("to kept", q, 32'h10);
      wb(0, CTL_OFS, 0);
      check("on cleared", q[15:0], 32'(c << 2));
      wb(1, RCF_OFS, 0);
      wb(0, RCF_OFS, 0);
      check("flag clr", q, 0);
    end
    pins.postscaler_config <= 5'h00;
    do_reset();
  endtask : s_period
  // Free-clear servicing holds off reset; reset follows once servicing stops
  task automatic s_service();
    int i, old;
    old = n_rst;
    wb(1, SET_A, 32'h8000);
    for (i = 0; i < 6; i++) begin
      repeat (70) @(posedge clk);
      wb(1, SET_A, 32'h1);
      wb(1, CTL_OFS, 32'h8000);
    end
    check("no reset", n_rst - old, 0);
    wait_ev(n_rst, old, 200);
    do_reset();
  endtask : s_service
  // Window sizes: service just before and just after threshold
  task automatic s_window();
    int sz, e, t0, old, tick;
    int thr[4] = '{8, 16, 20, 24};
    for (sz = 0; sz < 4; sz++) begin
      for (e = 0; e < 2; e++) begin
        pins.nv_window_size <= 2'(sz);
        do_reset();
        wb(1, SET_A, 32'h8002);
        t0 = cyc_n;
        tick = e ? thr[sz] - 3 : thr[sz] + 3;
        repeat (tick * DIV_T - 4) @(posedge clk);
        old = n_rst;
        wb(1, SET_A, 32'h1);
        repeat (3) @(posedge clk);
        check("early svc", n_rst - old, e);
      end
    end
    pins.nv_window_size <= 2'h0;
    do_reset();
  endtask : s_window
  // Time-out in Sleep, then Idle: wake event, flags, resume delay
  task automatic s_power();
    int m, old, oldr, t0;
    for (m = 0; m < 2; m++) begin
      do_reset();
      wb(1, RCF_OFS, 0);
      pins.sleep <= (m == 0);
      pins.idle <= (m == 1);
      old = n_rst;
      oldr = n_res;
      wb(1, SET_A, 32'h8000);
      t0 = cyc_n;
      repeat (80) @(posedge clk);
      pins.irq_wake <= 1'b1;
      repeat (4) @(posedge clk);
      pins.irq_wake <= 1'b0;
      wait_ev(n_nmi, n_nmi, 300);
      check("irq clear", t_nmi - t0 > 180, 1);
      wait_ev(n_res, oldr, 100);
      check("no dev reset", n_rst - old, 0);
      check("resume gap", m ? (t_res == t_nmi)
            : (t_res - t_nmi >= POWER_UP_DELAY_TIMER_T * DIV_T - DIV_T), 1);
      wb(0, RCF_OFS, 0);
      check("pm flags", q, m ? 32'h14 : 32'h18);
      wb(0, CTL_OFS, 0);
      check("on kept", q, 32'h8000);
      pins.sleep <= 1'b0;
      pins.idle <= 1'b0;
    end
    do_reset();
  endtask : s_power
  // Fuse enable and fuse window survive writes and resets
  task automatic s_config();
    int old;
    pins.nv_watchdog_enable <= 1'b1;
    pins.nv_window_enable <= 1'b1;
    do_reset();
    old = n_rst;
    wb(1, CLR_A, 32'h8002);
    wb(0, CTL_OFS, 0);
    check("fuse on", q, 32'h8002);
    check("fuse osc", osc_on, 1);
    do_reset();
    wb(0, CTL_OFS, 0);
    check("fuse kept", q, 32'h8002);
    wait_ev(n_rst, old, 200);
    pins.nv_watchdog_enable <= 1'b0;
    pins.nv_window_enable <= 1'b0;
    do_reset();
  endtask : s_config
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // Main sequence; power-up pin defines the time-out flag first
  initial begin
    rst_b = 1'b0;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'hf;
    dat_w = 32'h0;
    pins = '0;
    pins.power_up = 1'b1;
    pins.osc_ready = 1'b1;
    pins.power_up_delay_timer_enable = 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    pins.power_up <= 1'b0;
    repeat (4) @(posedge clk);
    s_regs();
    s_enable();
    s_period();
    s_service();
    s_window();
    s_power();
    s_config();
    final_report();
  end
endmodule : tb_top
